// ==== hdl/ebcp_pkg.sv ====
// Constants and types of the phased external bus cycle controller.
// Assumes one request at a time from the host side and a quasi-static timing table.
//
// Summary of operation
// - Two to five phases in fixed order per cycle
// - Phase lengths from per-chip-select timing
// - Setup 1-2 periods, plus 0-3 on window change
// - Command 0-3, write setup 0-1, hold 0-3
// - Access 1-32 periods, ready may extend it
// - Drive strobes, enables, select, address, data
// - Multiplexed and demultiplexed data modes
// - System clock routed to reference clock output
// - Read data latched at strobe release edge
// - Ready polarity selectable, sync or async
// - Ready inactive waits, active ends access
package ebcp_pkg;

	// ------------------------------------------------------------
	// Widths and sizes
	// ------------------------------------------------------------
	localparam int ADDR_W   = 24;
	localparam int DATA_W   = 16;
	localparam int CS_IDX_W = 2;
	localparam int NUM_CS   = 1 << CS_IDX_W;
	localparam int CNT_W    = 5;

	// ------------------------------------------------------------
	// Phase length encodings
	// ------------------------------------------------------------
	localparam logic [2:0]       SETUP_BASE  = 3'h1;
	localparam logic [1:0]       LEN2_ONE    = 2'h1;
	localparam logic [CNT_W-1:0] CNT_ZERO    = 5'h00;
	localparam logic [2:0]       CNT_HI_ZERO = 3'h0;

	typedef struct packed {
		logic       setup_long;
		logic [1:0] window_ext;
		logic [1:0] cmd_delay;
		logic       write_setup;
		logic [4:0] access;
		logic [1:0] hold;
		logic       rdy_en;
		logic       rdy_active_high;
		logic       rdy_async;
	} ebcp_timing_t;

	typedef struct packed {
		logic                write;
		logic [CS_IDX_W-1:0] cs;
		logic [ADDR_W-1:0]   addr;
		logic [DATA_W-1:0]   wdata;
		logic                lo_en;
		logic                hi_en;
	} ebcp_req_t;

	typedef struct packed {
		ebcp_req_t    req;
		ebcp_timing_t tim;
		logic         mux;
	} ebcp_job_t;

	typedef enum logic [2:0] {
		PH_IDLE,
		PH_ADDR,
		PH_CMD,
		PH_WSET,
		PH_ACC,
		PH_HOLD
	} ebcp_phase_t;

	typedef struct packed {
		ebcp_phase_t      ph;
		logic [CNT_W-1:0] cnt;
	} ebcp_step_t;

endpackage

// ==== hdl/ebcp_sync.sv ====
// Two-flop level synchroniser, one per bit.
// Assumes inputs are levels or toggles that stay put for two destination edges.
`timescale 1ns/100ps
module ebcp_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             CLK,
	input  wire logic             RST_B,
	input  wire logic [WIDTH-1:0] D,
	output logic      [WIDTH-1:0] Q
);
	logic [WIDTH-1:0] meta_q;

	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			meta_q <= '0;
			Q      <= '0;
		end else begin
			meta_q <= D;
			Q      <= meta_q;
		end
	end
endmodule

// ==== hdl/ebcp_top.sv ====
// Phased external bus cycle controller: host request port on REF_CLK,
// bus sequencer and pins on the bus system clock BUS_CLK.
// Assumes the host holds REQ stable only at the accepting edge.
`timescale 1ns/100ps
module ebcp_top
	import ebcp_pkg::*;
(
	input  wire logic                       REF_CLK,
	input  wire logic                       RST_B,
	input  wire logic                       BUS_CLK,
	input  wire logic                       REQ_VALID,
	input  wire ebcp_req_t                  REQ,
	input  wire ebcp_timing_t [NUM_CS-1:0]  CS_TIMING,
	input  wire logic                       MUX_MODE,
	input  wire logic                       REF_CLK_OUT_EN,
	output logic                            REQ_READY,
	output logic                            RSP_VALID,
	output logic [DATA_W-1:0]               RSP_RDATA,
	output logic [ADDR_W-1:0]               ADDR,
	output logic [DATA_W-1:0]               AD_OUT,
	output logic                            AD_OE_N,
	input  wire logic [DATA_W-1:0]          AD_IN,
	output logic                            ALE,
	output logic                            RD_N,
	output logic                            WRL_N,
	output logic                            WRH_N,
	output logic                            BYTE_HIGH_ENABLE_N,
	output logic [NUM_CS-1:0]               CS_N,
	input  wire logic                       READY_IN,
	output logic                            EXTERNAL_CLOCK_OUTPUT
);

	// ------------------------------------------------------------
	// Host side, REF_CLK domain
	// ------------------------------------------------------------
	ebcp_job_t          job_q;
	logic               req_tgl_q;
	logic               ack_seen_q;
	logic               ack_s;
	logic               ack_tgl_q;
	logic [DATA_W-1:0]  rdata_q;

	ebcp_sync #(.WIDTH(1)) u_ack_sync (
		.CLK   (REF_CLK),
		.RST_B (RST_B),
		.D     (ack_tgl_q),
		.Q     (ack_s)
	);

	// Accept one request, carry its chip-select timing along
	always_ff @(posedge REF_CLK or negedge RST_B) begin
		if (!RST_B) begin
			job_q      <= '0;
			req_tgl_q  <= 1'b0;
			REQ_READY  <= 1'b1;
		end else if (REQ_READY && REQ_VALID) begin
			job_q.req  <= REQ;
			job_q.tim  <= CS_TIMING[REQ.cs];
			job_q.mux  <= MUX_MODE;
			req_tgl_q  <= ~req_tgl_q;
			REQ_READY  <= 1'b0;
		end else if (ack_s != ack_seen_q) begin
			REQ_READY  <= 1'b1;
		end
	end

	// Completion pulse and read data hand-back
	always_ff @(posedge REF_CLK or negedge RST_B) begin
		if (!RST_B) begin
			ack_seen_q <= 1'b0;
			RSP_VALID  <= 1'b0;
			RSP_RDATA  <= '0;
		end else begin
			ack_seen_q <= ack_s;
			RSP_VALID  <= (ack_s != ack_seen_q);
			if (ack_s != ack_seen_q) begin
				RSP_RDATA <= rdata_q;
			end
		end
	end

	// ------------------------------------------------------------
	// Bus side, BUS_CLK domain
	// ------------------------------------------------------------
	logic               req_s;
	logic               rdy_s;
	logic               clk_en_s;
	logic               req_seen_q;
	logic               rdy_late_q;
	logic               clk_en_neg_q;
	ebcp_phase_t        state_q;
	ebcp_phase_t        state_d;
	logic [CNT_W-1:0]   cnt_q;
	logic [CNT_W-1:0]   cnt_d;
	logic [CS_IDX_W-1:0] last_cs_q;
	logic               last_cs_vld_q;
	logic               start;
	logic               finish;
	logic               leave_acc;
	logic               rdy_ok;
	logic               rdy_sample;
	logic [2:0]         ab_len;
	ebcp_step_t         nxt;

	ebcp_sync #(.WIDTH(3)) u_bus_sync (
		.CLK   (BUS_CLK),
		.RST_B (RST_B),
		.D     ({req_tgl_q, READY_IN, REF_CLK_OUT_EN}),
		.Q     ({req_s, rdy_s, clk_en_s})
	);

	// Next non-empty phase after the given one
	function automatic ebcp_step_t step_after(input ebcp_phase_t ph, input ebcp_timing_t t);
		ebcp_step_t s;
		s.ph  = PH_IDLE;
		s.cnt = CNT_ZERO;
		if (ph <= PH_ADDR && t.cmd_delay != 2'h0) begin
			s.ph  = PH_CMD;
			s.cnt = {CNT_HI_ZERO, t.cmd_delay - LEN2_ONE};
		end else if (ph <= PH_CMD && t.write_setup) begin
			s.ph  = PH_WSET;
		end else if (ph <= PH_WSET) begin
			s.ph  = PH_ACC;
			s.cnt = t.access;
		end else if (ph == PH_ACC && t.hold != 2'h0) begin
			s.ph  = PH_HOLD;
			s.cnt = {CNT_HI_ZERO, t.hold - LEN2_ONE};
		end
		return s;
	endfunction

	assign start = (state_q == PH_IDLE) && (req_s != req_seen_q);

	// Setup phase, lengthened when the chip select window moves
	always_comb begin
		ab_len = SETUP_BASE + {2'h0, job_q.tim.setup_long};
		if (!last_cs_vld_q || last_cs_q != job_q.req.cs) begin
			ab_len = ab_len + {1'b0, job_q.tim.window_ext};
		end
	end

	// Extra stage only in asynchronous mode costs one wait state
	assign rdy_sample = job_q.tim.rdy_async ? rdy_late_q : rdy_s;
	assign rdy_ok     = !job_q.tim.rdy_en || (rdy_sample == job_q.tim.rdy_active_high);
	assign nxt        = step_after(state_q, job_q.tim);

	// Phase sequencer
	always_comb begin
		state_d   = state_q;
		cnt_d     = cnt_q;
		leave_acc = 1'b0;
		unique case (state_q)
			PH_IDLE: begin
				if (start) begin
					state_d = PH_ADDR;
					cnt_d   = {2'h0, ab_len - SETUP_BASE};
				end
			end
			PH_ACC: begin
				if (cnt_q != CNT_ZERO) begin
					cnt_d = cnt_q - 5'h01;
				end else if (rdy_ok) begin
					leave_acc = 1'b1;
					state_d   = nxt.ph;
					cnt_d     = nxt.cnt;
				end
			end
			PH_ADDR, PH_CMD, PH_WSET, PH_HOLD: begin
				if (cnt_q != CNT_ZERO) begin
					cnt_d = cnt_q - 5'h01;
				end else begin
					state_d = nxt.ph;
					cnt_d   = nxt.cnt;
				end
			end
		endcase
	end

	assign finish = (state_q != PH_IDLE) && (state_d == PH_IDLE);

	always_ff @(posedge BUS_CLK or negedge RST_B) begin
		if (!RST_B) begin
			state_q <= PH_IDLE;
			cnt_q   <= CNT_ZERO;
		end else begin
			state_q <= state_d;
			cnt_q   <= cnt_d;
		end
	end

	// Request and completion toggles, window tracking
	always_ff @(posedge BUS_CLK or negedge RST_B) begin
		if (!RST_B) begin
			req_seen_q    <= 1'b0;
			ack_tgl_q     <= 1'b0;
			last_cs_q     <= '0;
			last_cs_vld_q <= 1'b0;
			rdy_late_q    <= 1'b0;
		end else begin
			rdy_late_q <= rdy_s;
			if (start) begin
				req_seen_q    <= req_s;
				last_cs_q     <= job_q.req.cs;
				last_cs_vld_q <= 1'b1;
			end
			if (finish) begin
				ack_tgl_q <= ~ack_tgl_q;
			end
		end
	end

	// Read data taken on the edge that releases the read strobe
	always_ff @(posedge BUS_CLK or negedge RST_B) begin
		if (!RST_B) begin
			rdata_q <= '0;
		end else if (leave_acc && !job_q.req.write) begin
			rdata_q <= AD_IN;
		end
	end

	// ------------------------------------------------------------
	// Pin outputs, registered from the next phase
	// ------------------------------------------------------------
	logic active_d;
	logic strobe_d;
	logic drive_d;

	assign active_d = (state_d != PH_IDLE);
	assign strobe_d = (state_d == PH_WSET) || (state_d == PH_ACC);

	always_comb begin
		drive_d = 1'b0;
		if (job_q.mux) begin
			drive_d = (state_d == PH_ADDR) || (state_d == PH_CMD) ||
				(job_q.req.write && active_d);
		end else begin
			drive_d = job_q.req.write && active_d;
		end
	end

	always_ff @(posedge BUS_CLK or negedge RST_B) begin
		if (!RST_B) begin
			ADDR               <= '0;
			AD_OUT             <= '0;
			AD_OE_N            <= 1'b1;
			ALE                <= 1'b0;
			RD_N               <= 1'b1;
			WRL_N              <= 1'b1;
			WRH_N              <= 1'b1;
			BYTE_HIGH_ENABLE_N <= 1'b1;
			CS_N               <= '1;
		end else begin
			if (start) begin
				ADDR <= job_q.req.addr;
			end
			if (job_q.mux && (state_d == PH_ADDR || state_d == PH_CMD)) begin
				AD_OUT <= job_q.req.addr[DATA_W-1:0];
			end else if (active_d) begin
				// Idle holds, the host side may be rewriting the job
				AD_OUT <= job_q.req.wdata;
			end
			AD_OE_N            <= ~drive_d;
			ALE                <= (state_d == PH_ADDR);
			RD_N               <= ~(strobe_d && !job_q.req.write);
			WRL_N              <= ~(strobe_d && job_q.req.write && job_q.req.lo_en);
			WRH_N              <= ~(strobe_d && job_q.req.write && job_q.req.hi_en);
			BYTE_HIGH_ENABLE_N <= ~(active_d && job_q.req.hi_en);
			for (int i = 0; i < NUM_CS; i++) begin
				CS_N[i] <= ~(active_d && (job_q.req.cs == i[CS_IDX_W-1:0]));
			end
		end
	end

	// ------------------------------------------------------------
	// Reference clock output
	// ------------------------------------------------------------
	// Enable changes only while the clock is low, so no runt pulses
	always_ff @(negedge BUS_CLK or negedge RST_B) begin
		if (!RST_B) begin
			clk_en_neg_q <= 1'b0;
		end else begin
			clk_en_neg_q <= clk_en_s;
		end
	end

	assign EXTERNAL_CLOCK_OUTPUT = BUS_CLK & clk_en_neg_q;

endmodule

// ==== verif/ebcp_mem_model.sv ====
// Bus memory model, 256 words, ready after a set count of strobe cycles.
// Assumes the full address pins in both modes.
`timescale 1ns/100ps
module ebcp_mem_model
	import ebcp_pkg::*;
(
	input  wire logic              bus_clk,
	input  wire logic [ADDR_W-1:0] addr,
	input  wire logic [NUM_CS-1:0] cs_n,
	input  wire logic              rd_n,
	input  wire logic              wrl_n,
	input  wire logic              wrh_n,
	input  wire logic [DATA_W-1:0] ad_out,
	input  wire logic [4:0]        wait_n,
	input  wire logic              rdy_pol,
	output logic      [DATA_W-1:0] ad_in,
	output logic                   ready
);
	logic [DATA_W-1:0] mem [256];
	logic [DATA_W-1:0] last_q = '0;
	logic [4:0]        cnt_q;
	logic              sel;
	logic              strb;
	assign sel = cs_n != 4'hf;
	assign strb = sel && !(rd_n && wrl_n && wrh_n);
	// Released lines toggle every cycle
	assign ad_in = (sel && !rd_n) ? mem[addr[7:0]] : ~last_q;
	always @(posedge bus_clk) last_q <= ad_in;
	always_ff @(posedge bus_clk) begin
		if (sel && !wrl_n) mem[addr[7:0]][7:0] <= ad_out[7:0];
		if (sel && !wrh_n) mem[addr[7:0]][15:8] <= ad_out[15:8];
	end
	always_ff @(posedge bus_clk) cnt_q <= strb ? cnt_q + 5'h01 : 5'h00;
	// Ready withdrawn as the strobe ends
	assign ready = rdy_pol ~^ (strb && cnt_q >= wait_n);
endmodule

// ==== verif/ebcp_top_chk.sv ====
// Pin checker for the phased bus controller, bound to its top.
// Assumes one reset for both clock domains.
`timescale 1ns/100ps
module ebcp_top_chk
	import ebcp_pkg::*;
(
	input wire logic              BUS_CLK,
	input wire logic              RST_B,
	input wire logic              ALE,
	input wire logic              RD_N,
	input wire logic              WRL_N,
	input wire logic              WRH_N,
	input wire logic              AD_OE_N,
	input wire logic [NUM_CS-1:0] CS_N,
	input wire logic [ADDR_W-1:0] ADDR
);
	logic strb;
	assign strb = !(RD_N && WRL_N && WRH_N);
	default clocking @(posedge BUS_CLK); endclocking
	default disable iff (!RST_B);
	property p_ale_cs; ALE |-> CS_N != 4'hf; endproperty
	a_ale_cs: assert property (p_ale_cs) else $error("ALE without select");
	property p_gap; $rose(ALE) |-> $past(CS_N) == 4'hf; endproperty
	a_gap: assert property (p_gap) else $error("Cycle without idle gap");
	property p_str_ale; strb |-> !ALE; endproperty
	a_str_ale: assert property (p_str_ale) else $error("Strobe in setup");
	property p_str_cs; strb |-> CS_N != 4'hf; endproperty
	a_str_cs: assert property (p_str_cs) else $error("Strobe without select");
	property p_rd_wr; !RD_N |-> WRL_N && WRH_N; endproperty
	a_rd_wr: assert property (p_rd_wr) else $error("Read and write strobes");
	property p_rd_tri; !RD_N |-> AD_OE_N; endproperty
	a_rd_tri: assert property (p_rd_tri) else $error("Data driven in read");
	property p_wr_drv; !(WRL_N && WRH_N) |-> !AD_OE_N; endproperty
	a_wr_drv: assert property (p_wr_drv) else $error("Write data not driven");
	property p_addr; CS_N != 4'hf && $past(CS_N) != 4'hf |-> $stable(ADDR); endproperty
	a_addr: assert property (p_addr) else $error("Address moved in cycle");
	property p_cmd; $fell(ALE) |-> ##[0:3] strb; endproperty
	a_cmd: assert property (p_cmd) else $error("Command delay too long");
endmodule
bind ebcp_top ebcp_top_chk ebcp_top_chk_inst (.BUS_CLK(BUS_CLK), .RST_B(RST_B), .ALE(ALE), .RD_N(RD_N),
	.WRL_N(WRL_N), .WRH_N(WRH_N), .AD_OE_N(AD_OE_N), .CS_N(CS_N), .ADDR(ADDR));

// ==== verif/tb_ebcp_top.sv ====
// Testbench of the phased bus controller.
// Assumes the memory model on the bus pins.
`timescale 1ns/100ps
module tb_ebcp_top;
	import ebcp_pkg::*;
	logic REF_CLK, BUS_CLK, RST_B, REQ_VALID, MUX_MODE, REF_CLK_OUT_EN, REQ_READY, RSP_VALID;
	logic AD_OE_N, ALE, RD_N, WRL_N, WRH_N, BYTE_HIGH_ENABLE_N, READY_IN, EXTERNAL_CLOCK_OUTPUT;
	logic [DATA_W-1:0] RSP_RDATA, AD_OUT, AD_IN;
	logic [ADDR_W-1:0] ADDR;
	logic [NUM_CS-1:0] CS_N;
	ebcp_req_t         REQ;
	ebcp_timing_t [NUM_CS-1:0] CS_TIMING;
	logic [4:0] wait_n;
	logic       rdy_pol;
	int miscompares = 0, comparisons = 0, cyc = 0, n_ale, n_str, n_cs, n_bhe;
	ebcp_top ebcp_top_inst (.REF_CLK(REF_CLK), .RST_B(RST_B), .BUS_CLK(BUS_CLK), .REQ_VALID(REQ_VALID),
		.REQ(REQ), .CS_TIMING(CS_TIMING), .MUX_MODE(MUX_MODE), .REF_CLK_OUT_EN(REF_CLK_OUT_EN),
		.REQ_READY(REQ_READY), .RSP_VALID(RSP_VALID), .RSP_RDATA(RSP_RDATA), .ADDR(ADDR), .AD_OUT(AD_OUT),
		.AD_OE_N(AD_OE_N), .AD_IN(AD_IN), .ALE(ALE), .RD_N(RD_N), .WRL_N(WRL_N), .WRH_N(WRH_N),
		.BYTE_HIGH_ENABLE_N(BYTE_HIGH_ENABLE_N), .CS_N(CS_N), .READY_IN(READY_IN),
		.EXTERNAL_CLOCK_OUTPUT(EXTERNAL_CLOCK_OUTPUT));
	ebcp_mem_model ebcp_mem_model_inst (.bus_clk(BUS_CLK), .addr(ADDR), .cs_n(CS_N), .rd_n(RD_N),
		.wrl_n(WRL_N), .wrh_n(WRH_N), .ad_out(AD_OUT), .wait_n(wait_n), .rdy_pol(rdy_pol),
		.ad_in(AD_IN), .ready(READY_IN));
	initial begin
		REF_CLK = 1'h0;
		forever #10 REF_CLK = ~REF_CLK;
	end
	initial begin
		BUS_CLK = 1'h0;
		#7;
		forever #62.5 BUS_CLK = ~BUS_CLK;
	end
	always @(posedge BUS_CLK) begin
		if (ALE) n_ale++;
		if (!(RD_N && WRL_N && WRH_N)) n_str++;
		if (CS_N != 4'hf) n_cs++;
		if (!BYTE_HIGH_ENABLE_N) n_bhe++;
	end
	always @(posedge REF_CLK) begin
		cyc++;
		if (cyc == 20000) begin
			miscompares++;
			conclude;
		end
	end
	task chk(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task chkn(input int got, input int exp);
		comparisons++;
		if (got != exp) begin
			miscompares++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task xfer(input logic w, input logic [1:0] cs, input logic [23:0] a, input logic [15:0] d,
		input logic lo, input logic hi, output logic [15:0] r);
		int n;
		n = 0;
		n_ale = 0;
		n_str = 0;
		n_cs = 0;
		n_bhe = 0;
		REQ <= {w, cs, a, d, lo, hi};
		REQ_VALID <= 1'h1;
		@(posedge REF_CLK);
		REQ_VALID <= 1'h0;
		@(negedge REF_CLK);
		chk({15'h0000, REQ_READY}, 16'h0000);
		do begin
			@(negedge REF_CLK);
			n++;
		end while (RSP_VALID !== 1'h1 && n < 3000);
		r = RSP_RDATA;
		chkn(n < 3000, 1);
		chk({15'h0000, REQ_READY}, 16'h0001);
		@(posedge REF_CLK);
	endtask
	task t_demux;
		logic [15:0] r;
		MUX_MODE <= 1'h0;
		xfer(1'h1, 2'h0, 24'h00_0010, 16'ha5c3, 1'h1, 1'h1, r);
		chkn(n_ale, 3);
		chkn(n_cs, 4);
		xfer(1'h0, 2'h0, 24'h00_0010, 16'h0000, 1'h1, 1'h1, r);
		chk(r, 16'ha5c3);
		chkn(n_ale, 1);
		chkn(n_str, 1);
		xfer(1'h1, 2'h0, 24'h00_0010, 16'h7700, 1'h0, 1'h1, r);
		xfer(1'h0, 2'h0, 24'h00_0010, 16'h0000, 1'h1, 1'h1, r);
		chk(r, 16'h77c3);
		@(posedge BUS_CLK);
		#1;
		chk({15'h0000, EXTERNAL_CLOCK_OUTPUT}, 16'h0000);
		@(posedge REF_CLK);
	endtask
	task t_mux;
		logic [15:0] r;
		MUX_MODE <= 1'h1;
		xfer(1'h1, 2'h1, 24'h00_0020, 16'h1234, 1'h1, 1'h1, r);
		chkn(n_ale, 5);
		chkn(n_str, 33);
		chkn(n_cs, 44);
		chkn(n_bhe, 44);
		xfer(1'h1, 2'h1, 24'h00_0020, 16'h55ef, 1'h1, 1'h0, r);
		chkn(n_ale, 2);
		chkn(n_bhe, 0);
		xfer(1'h0, 2'h1, 24'h00_0020, 16'h0000, 1'h1, 1'h1, r);
		chk(r, 16'h12ef);
	endtask
	task t_ready;
		logic [15:0] r;
		MUX_MODE <= 1'h0;
		REF_CLK_OUT_EN <= 1'h1;
		wait_n <= 5'h04;
		xfer(1'h1, 2'h2, 24'h00_0031, 16'h0f0f, 1'h1, 1'h1, r);
		chkn(n_str > 4, 1);
		rdy_pol <= 1'h0;
		wait_n <= 5'h02;
		xfer(1'h0, 2'h3, 24'h00_0031, 16'h0000, 1'h1, 1'h1, r);
		chk(r, 16'h0f0f);
		chkn(n_str > 2, 1);
		@(posedge BUS_CLK);
		#1;
		chk({15'h0000, EXTERNAL_CLOCK_OUTPUT}, 16'h0001);
		@(posedge REF_CLK);
	endtask
	task conclude;
		$display("miscompares=%0d comparisons=%0d", miscompares, comparisons);
		if (miscompares == 0 && comparisons > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		RST_B = 1'h0;
		REQ_VALID = 1'h0;
		REQ = '0;
		MUX_MODE = 1'h0;
		REF_CLK_OUT_EN = 1'h0;
		wait_n = 5'h00;
		rdy_pol = 1'h1;
		CS_TIMING[0] = {1'h0, 2'h2, 2'h0, 1'h0, 5'h00, 2'h0, 3'h0};
		CS_TIMING[1] = {1'h1, 2'h3, 2'h3, 1'h1, 5'h1f, 2'h3, 3'h0};
		CS_TIMING[2] = {1'h0, 2'h0, 2'h0, 1'h0, 5'h00, 2'h0, 3'h7};
		CS_TIMING[3] = {1'h0, 2'h0, 2'h1, 1'h0, 5'h00, 2'h0, 3'h4};
		repeat (12) @(posedge REF_CLK);
		RST_B <= 1'h1;
		@(posedge REF_CLK);
		t_demux;
		t_mux;
		t_ready;
		conclude;
	end
endmodule
